/* File: verilog/mixer_pkg.sv */
`default_nettype none
package mixer_pkg;
  localparam int SAMPLE_W = 16;
  localparam int FREQ_W = 32;
  localparam int POFF_W = 16;
  localparam int SYNC_W = 4;
  localparam int CSEL_W = 4;
  localparam int GAIN_W = 11;
  localparam int GAIN_FRAC = 10;
  localparam int QPH_W = 12;
  localparam int QPH_FRAC = 12;
  localparam int OFFS_W = 13;
  localparam int LUT_AW = 6;
  localparam int TRIG_FRAC = 15;
  localparam int WIDE_W = 40;
  localparam int LATENCY = 5;
  localparam int CSEL_NEG4 = 0;
  localparam int CSEL_FS2 = 1;
  localparam int CSEL_POS4 = 2;
  localparam int CSEL_FS8 = 3;
  localparam logic [GAIN_W-1:0] GAIN_ONE = 11'h400;
  localparam logic [FREQ_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [LUT_AW-1:0] QUARTER_STEP = 6'h10;
  localparam logic [2:0] FS8_RST = 3'h0;
  localparam logic [1:0] SEQ_RST = 2'h0;

  typedef logic signed [SAMPLE_W-1:0] sample_t;
  typedef logic [1:0] rot_t;

  localparam sample_t SMAX = 16'sh7FFF;
  localparam sample_t SMIN = 16'sh8000;
  localparam sample_t SZERO = 16'sh0000;

  // ************************************************
  // Saturation helpers
  // ************************************************
  function automatic sample_t sat16(input logic signed [WIDE_W-1:0] v);
    if (v > WIDE_W'(SMAX)) begin
      return SMAX;
    end else if (v < WIDE_W'(SMIN)) begin
      return SMIN;
    end
    return v[SAMPLE_W-1:0];
  endfunction

  function automatic sample_t neg16(input sample_t v);
    return sat16(-WIDE_W'(v));
  endfunction
endpackage
`default_nettype wire

/* File: verilog/iq_sample_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface iq_sample_if;
  import mixer_pkg::*;
  sample_t re;
  sample_t im;
  modport src(output re, output im);
  modport dst(input re, input im);
endinterface
`default_nettype wire

/* File: verilog/osc_sine_rom.sv */
`timescale 1ns/1ns
`default_nettype none
module osc_sine_rom (
  input wire logic i_clk,
  input wire logic [mixer_pkg::LUT_AW-1:0] i_sin_idx,
  output mixer_pkg::sample_t o_sin,
  output mixer_pkg::sample_t o_cos
);
  import mixer_pkg::*;

  // ************************************************
  // Quarter wave table, full wave by symmetry
  // ************************************************
  function automatic sample_t quarter(input logic [4:0] k);
    case (k)
      5'h00: quarter = 16'sh0000;
      5'h01: quarter = 16'sh0C8C;
      5'h02: quarter = 16'sh18F9;
      5'h03: quarter = 16'sh2528;
      5'h04: quarter = 16'sh30FC;
      5'h05: quarter = 16'sh3C57;
      5'h06: quarter = 16'sh471D;
      5'h07: quarter = 16'sh5134;
      5'h08: quarter = 16'sh5A82;
      5'h09: quarter = 16'sh62F2;
      5'h0A: quarter = 16'sh6A6E;
      5'h0B: quarter = 16'sh70E3;
      5'h0C: quarter = 16'sh7642;
      5'h0D: quarter = 16'sh7A7D;
      5'h0E: quarter = 16'sh7D8A;
      5'h0F: quarter = 16'sh7F62;
      default: quarter = 16'sh7FFF;
    endcase
  endfunction

  function automatic sample_t wave(input logic [LUT_AW-1:0] a);
    logic [4:0] k;
    k = a[4] ? 5'(5'h10 - {1'b0, a[3:0]}) : {1'b0, a[3:0]};
    wave = a[5] ? -quarter(k) : quarter(k);
  endfunction

  logic [LUT_AW-1:0] cos_idx;
  assign cos_idx = i_sin_idx + QUARTER_STEP;

  always_ff @(posedge i_clk) begin
    o_sin <= wave(i_sin_idx);
    o_cos <= wave(cos_idx);
  end
endmodule
`default_nettype wire

/* File: verilog/coarse_rotator.sv */
`timescale 1ns/1ns
`default_nettype none
module coarse_rotator (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sync,
  input wire logic [2:0] i_rot_sel,
  iq_sample_if.dst up,
  iq_sample_if.src down
);
  import mixer_pkg::*;

  logic [1:0] seq_n;
  rot_t rot;

  // ************************************************
  // Sample position within the four-sample cycle
  // ************************************************
  always_ff @(posedge i_clk) begin
    if (!i_nrst || i_sync) begin
      seq_n <= SEQ_RST;
    end else begin
      seq_n <= seq_n + 2'h1;
    end
  end

  // Rotation by j^rot, stages composed by bit
  always_comb begin
    rot = '0;
    if (i_rot_sel[CSEL_FS2]) begin
      rot = rot + {seq_n[0], 1'b0};
    end
    if (i_rot_sel[CSEL_POS4]) begin
      rot = rot + seq_n;
    end
    if (i_rot_sel[CSEL_NEG4]) begin
      rot = rot - seq_n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      down.re <= SZERO;
      down.im <= SZERO;
    end else begin
      case (rot)
        2'h0: begin
          down.re <= up.re;
          down.im <= up.im;
        end
        2'h1: begin
          down.re <= neg16(up.im);
          down.im <= up.re;
        end
        2'h2: begin
          down.re <= neg16(up.re);
          down.im <= neg16(up.im);
        end
        default: begin
          down.re <= up.im;
          down.im <= neg16(up.re);
        end
      endcase
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_bypass_passes: assert property (i_rot_sel == 3'h0 |=> down.re == $past(up.re) && down.im == $past(up.im)) else $error("bypass altered sample");
  a_half_rate_neg: assert property (i_rot_sel == 3'h2 && seq_n == 2'h1 |=> down.re == neg16($past(up.re)) && down.im == neg16($past(up.im))) else $error("half rate sign wrong");
  a_quarter_pos_seq: assert property (i_rot_sel == 3'h4 && seq_n == 2'h1 |=> down.re == neg16($past(up.im)) && down.im == $past(up.re)) else $error("positive quarter sequence wrong");
  a_quarter_neg_seq: assert property (i_rot_sel == 3'h1 && seq_n == 2'h3 |=> down.re == neg16($past(up.im)) && down.im == $past(up.re)) else $error("negative quarter sequence wrong");
endmodule
`default_nettype wire

/* File: verilog/complex_mixer_iq_correction.sv */
`timescale 1ns/1ns
`default_nettype none
module complex_mixer_iq_correction (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire mixer_pkg::sample_t i_i_data,
  input wire mixer_pkg::sample_t i_q_data,
  input wire logic i_full_oscillator_mixer,
  input wire logic [mixer_pkg::FREQ_W-1:0] i_osc_freq_word,
  input wire logic [mixer_pkg::POFF_W-1:0] i_osc_phase_offset,
  input wire logic [mixer_pkg::SYNC_W-1:0] i_osc_sync_source_sel,
  input wire logic [mixer_pkg::SYNC_W-1:0] i_sync_pins,
  input wire logic [mixer_pkg::CSEL_W-1:0] i_coarse_sel,
  input wire logic i_mixer_gain,
  input wire logic [mixer_pkg::GAIN_W-1:0] i_qmc_gain,
  input wire logic [mixer_pkg::QPH_W-1:0] i_qmc_phase,
  input wire logic [mixer_pkg::OFFS_W-1:0] i_i_dc_offset_word,
  input wire logic [mixer_pkg::OFFS_W-1:0] i_q_dc_offset_word,
  output mixer_pkg::sample_t o_i_data,
  output mixer_pkg::sample_t o_q_data,
  output logic [mixer_pkg::FREQ_W-1:0] o_osc_phase
);
  import mixer_pkg::*;

  localparam sample_t HALF_PROBE = 16'sh3FFE;
  localparam sample_t EIGHTH_TERM = 16'sh5A82;
  localparam sample_t QPH_PROBE = 16'shC000;
  localparam logic [QPH_W-1:0] QPH_MIN = 12'h800;
  localparam logic [QPH_W-1:0] QPH_ZERO = 12'h000;
  localparam logic [OFFS_W-1:0] OFFS_ZERO = 13'h0000;
  localparam logic [CSEL_W-1:0] CSEL_NONE = 4'h0;
  localparam logic [CSEL_W-1:0] CSEL_EIGHTH = 4'h8;
  localparam logic [CSEL_W-1:0] CSEL_NEGQ = 4'h1;

  // ************************************************
  // Sync pin synchronisers and edge detect
  // ************************************************
  logic [SYNC_W-1:0] sy1;
  logic [SYNC_W-1:0] sy2;
  logic [SYNC_W-1:0] sy3;
  logic [SYNC_W-1:0] sy_lvl;
  logic [SYNC_W-1:0] sy_rise;
  logic sync_evt;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
      sy_lvl <= '0;
    end else begin
      sy1 <= i_sync_pins;
      sy2 <= sy1;
      sy3 <= sy2;
      sy_lvl <= (~(sy2 ^ sy3) & sy3) | ((sy2 ^ sy3) & sy_lvl);
    end
  end

  // A level change counts only once stages two and three agree
  assign sy_rise = sy2 & sy3 & ~sy_lvl;
  assign sync_evt = |(sy_rise & i_osc_sync_source_sel);

  // ************************************************
  // Oscillator accumulators
  // ************************************************
  logic [FREQ_W-1:0] acc;
  logic [2:0] fs8_cnt;
  logic [POFF_W-1:0] osc_phase;
  logic [LUT_AW-1:0] lut_idx;

  always_ff @(posedge i_clk) begin
    if (!i_nrst || sync_evt) begin
      acc <= ACC_RST;
    end else begin
      acc <= acc + i_osc_freq_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst || sync_evt) begin
      fs8_cnt <= FS8_RST;
    end else begin
      fs8_cnt <= fs8_cnt + 3'h1;
    end
  end

  assign o_osc_phase = acc;
  assign osc_phase = acc[FREQ_W-1 -: POFF_W] + i_osc_phase_offset;

  // Eighth-rate mode steps the table by one eighth turn per sample
  always_comb begin
    if (i_coarse_sel[CSEL_FS8]) begin
      lut_idx = {fs8_cnt, 3'h0};
    end else begin
      lut_idx = osc_phase[POFF_W-1 -: LUT_AW];
    end
  end

  // ************************************************
  // Sine and cosine terms
  // ************************************************
  sample_t trig_sin;
  sample_t trig_cos;

  osc_sine_rom u_rom (
    .i_clk(i_clk),
    .i_sin_idx(lut_idx),
    .o_sin(trig_sin),
    .o_cos(trig_cos)
  );

  // ************************************************
  // Input register, aligned with the table output
  // ************************************************
  sample_t d_i;
  sample_t d_q;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      d_i <= SZERO;
      d_q <= SZERO;
    end else begin
      d_i <= i_i_data;
      d_q <= i_q_data;
    end
  end

  // ************************************************
  // Complex multiplier
  // ************************************************
  logic mult_en;
  logic signed [WIDE_W-1:0] prod_i;
  logic signed [WIDE_W-1:0] prod_q;
  logic signed [WIDE_W-1:0] next_mi;
  logic signed [WIDE_W-1:0] next_mq;

  assign mult_en = i_full_oscillator_mixer | i_coarse_sel[CSEL_FS8];

  always_comb begin
    prod_i = WIDE_W'(d_i) * WIDE_W'(trig_cos) - WIDE_W'(d_q) * WIDE_W'(trig_sin);
    prod_q = WIDE_W'(d_i) * WIDE_W'(trig_sin) + WIDE_W'(d_q) * WIDE_W'(trig_cos);
    if (i_mixer_gain) begin
      next_mi = prod_i >>> TRIG_FRAC;
      next_mq = prod_q >>> TRIG_FRAC;
    end else begin
      next_mi = prod_i >>> (TRIG_FRAC + 1);
      next_mq = prod_q >>> (TRIG_FRAC + 1);
    end
  end

  iq_sample_if mix_bus ();
  iq_sample_if crs_bus ();

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mix_bus.re <= SZERO;
      mix_bus.im <= SZERO;
    end else if (mult_en) begin
      mix_bus.re <= sat16(next_mi);
      mix_bus.im <= sat16(next_mq);
    end else begin
      mix_bus.re <= d_i;
      mix_bus.im <= d_q;
    end
  end

  // ************************************************
  // Coarse sign and swap stage
  // ************************************************
  coarse_rotator u_coarse (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sync(sync_evt),
    .i_rot_sel(i_coarse_sel[CSEL_POS4:CSEL_NEG4]),
    .up(mix_bus.dst),
    .down(crs_bus.src)
  );

  // ************************************************
  // Correction gain
  // ************************************************
  sample_t g_i;
  sample_t g_q;
  logic signed [WIDE_W-1:0] gain_s;

  assign gain_s = WIDE_W'($signed({1'b0, i_qmc_gain}));

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      g_i <= SZERO;
      g_q <= SZERO;
    end else begin
      g_i <= sat16((WIDE_W'(crs_bus.re) * gain_s) >>> GAIN_FRAC);
      g_q <= sat16((WIDE_W'(crs_bus.im) * gain_s) >>> GAIN_FRAC);
    end
  end

  // ************************************************
  // Phase correction and DC offset
  // ************************************************
  logic signed [WIDE_W-1:0] skew;
  logic signed [WIDE_W-1:0] offs_i;
  logic signed [WIDE_W-1:0] offs_q;

  assign skew = (WIDE_W'(g_q) * WIDE_W'($signed(i_qmc_phase))) >>> QPH_FRAC;
  assign offs_i = WIDE_W'($signed(i_i_dc_offset_word));
  assign offs_q = WIDE_W'($signed(i_q_dc_offset_word));

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_i_data <= SZERO;
      o_q_data <= SZERO;
    end else begin
      o_i_data <= sat16(WIDE_W'(g_i) + skew + offs_i);
      o_q_data <= sat16(WIDE_W'(g_q) + offs_q);
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  logic neutral;
  assign neutral = i_qmc_gain == GAIN_ONE && i_qmc_phase == QPH_ZERO &&
    i_i_dc_offset_word == OFFS_ZERO && i_q_dc_offset_word == OFFS_ZERO &&
    i_coarse_sel == CSEL_NONE && !i_full_oscillator_mixer;

  a_sync_clears_acc: assert property (sync_evt |=> acc == ACC_RST) else $error("accumulator not cleared on sync");
  a_acc_steps_word: assert property (!sync_evt |=> acc == $past(acc) + $past(i_osc_freq_word)) else $error("accumulator step wrong");

  property p_offset_after_sync;
    (!i_coarse_sel[CSEL_FS8] && $past(sync_evt)) |-> lut_idx == i_osc_phase_offset[POFF_W-1 -: LUT_AW];
  endproperty
  a_phase_from_clear: assert property (p_offset_after_sync) else $error("phase not counted from clear");

  a_eighth_terms: assert property (i_coarse_sel[CSEL_FS8] && fs8_cnt == 3'h2 |=> trig_sin == SMAX && trig_cos == SZERO) else $error("eighth rate terms wrong");

  a_mult_half_scale: assert property (mult_en && !i_mixer_gain && trig_sin == SZERO && trig_cos == SMAX && d_i == SMAX |=> mix_bus.re == HALF_PROBE) else $error("half scale product wrong");

  a_mult_full_clip: assert property (mult_en && i_mixer_gain && trig_sin == EIGHTH_TERM && trig_cos == EIGHTH_TERM && d_i == SMAX && d_q == SMAX |=> mix_bus.re == SZERO && mix_bus.im == SMAX) else $error("complex product or clip wrong");

  a_mult_bypassed: assert property (!mult_en |=> mix_bus.re == $past(d_i) && mix_bus.im == $past(d_q)) else $error("multiplier not bypassed");

  a_gain_saturates: assert property (crs_bus.re == SMAX && i_qmc_gain > GAIN_ONE |=> g_i == SMAX) else $error("gain stage wrapped");

  a_neutral_path: assert property (neutral [*6] |-> o_i_data == $past(i_i_data, 5) && o_q_data == $past(i_q_data, 5)) else $error("unity path altered data");

  a_offset_lsb: assert property (crs_bus.im == SZERO && i_qmc_gain == GAIN_ONE |-> ##2 o_q_data == SAMPLE_W'($signed($past(i_q_dc_offset_word, 1)))) else $error("offset misaligned");

  sequence s_skew_setup;
    crs_bus.re == SZERO && crs_bus.im == SMAX && i_qmc_gain == GAIN_ONE;
  endsequence
  a_phase_skew: assert property (s_skew_setup ##1 (i_qmc_phase == QPH_MIN && i_i_dc_offset_word == OFFS_ZERO) |=> o_i_data == QPH_PROBE) else $error("phase term wrong");

  c_sync_seen: cover property (sync_evt);
  c_eighth_mode: cover property (i_coarse_sel == CSEL_EIGHTH ##4 o_i_data != SZERO);
  c_neg_quarter: cover property (i_coarse_sel == CSEL_NEGQ [*4]);
  c_output_clip: cover property (o_i_data == SMAX);
endmodule
`default_nettype wire

/* File: verification/iq_source_model.sv */
`timescale 1ns/1ns
`default_nettype none
module iq_source_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire mixer_pkg::sample_t i_next_i,
  input wire mixer_pkg::sample_t i_next_q,
  output var mixer_pkg::sample_t o_i,
  output var mixer_pkg::sample_t o_q
);
  import mixer_pkg::*;
  // ******************
  // Sample source
  // ******************
  initial begin
    o_i = SZERO;
    o_q = SZERO;
  end
  // One I/Q pair per clock, launched a fixed delay after the edge
  always @(posedge i_clk) begin
    o_i <= #1 i_nrst ? i_next_i : SZERO;
    o_q <= #1 i_nrst ? i_next_q : SZERO;
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mixer_pkg::*;
  logic i_clk, i_nrst, full, mgain;
  sample_t nxt_i, nxt_q, di, dq, oi, oq;
  logic [31:0] freq, ph, p0;
  logic [15:0] poff;
  logic [3:0] ssel, spins, csel;
  logic [10:0] qgain;
  logic [11:0] qph;
  logic [12:0] offi, offq;
  logic [31:0] v [16];
  logic [3:0] cs [4] = '{4'h0, 4'h2, 4'h4, 4'h1};
  logic [3:0] fc [5] = '{4'h8, 4'h8, 4'hA, 4'hC, 4'hE};
  int st [4] = '{0, 2, 1, 3};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int p, hits;

  iq_source_model iq_source_model_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_next_i(nxt_i),
    .i_next_q(nxt_q), .o_i(di), .o_q(dq));
  complex_mixer_iq_correction complex_mixer_iq_correction_inst (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_i_data(di), .i_q_data(dq), .i_full_oscillator_mixer(full),
    .i_osc_freq_word(freq), .i_osc_phase_offset(poff), .i_osc_sync_source_sel(ssel),
    .i_sync_pins(spins), .i_coarse_sel(csel), .i_mixer_gain(mgain), .i_qmc_gain(qgain),
    .i_qmc_phase(qph), .i_i_dc_offset_word(offi), .i_q_dc_offset_word(offq),
    .o_i_data(oi), .o_q_data(oq), .o_osc_phase(ph));

  // ******************
  // Helpers
  // ******************
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Quarter-turn rotation of a pair, packed as {I, Q}
  function automatic logic [31:0] rj(input int r, input sample_t a, input sample_t b);
    case (r & 3)
      0: return {a, b};
      1: return {-b, a};
      2: return {-a, -b};
      default: return {b, -a};
    endcase
  endfunction

  task automatic qmc(input logic [10:0] g, input logic [11:0] w, input logic [12:0] fi,
    input logic [12:0] fq, input sample_t a, input sample_t b, input logic [31:0] e);
    qgain = g;
    qph = w;
    offi = fi;
    offq = fq;
    nxt_i = a;
    nxt_q = b;
    tick(10);
    chk("qmc out", {oi, oq}, e);
  endtask

  task automatic mix(input logic [15:0] o, input logic g, input logic [31:0] e);
    poff = o;
    mgain = g;
    tick(10);
    chk("mixer out", {oi, oq}, e);
  endtask

  // ******************
  // Clock and watchdog
  // ******************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      results();
    end
  end

  // ******************
  // Tests
  // ******************
  initial begin
    i_nrst = 1'b0;
    full = 1'b0;
    mgain = 1'b1;
    nxt_i = SZERO;
    nxt_q = SZERO;
    freq = ACC_RST;
    poff = 16'h0000;
    ssel = 4'h0;
    spins = 4'h0;
    csel = 4'h0;
    qgain = GAIN_ONE;
    qph = 12'h000;
    offi = 13'h0000;
    offq = 13'h0000;
    tick(16);
    chk("reset out", {oi, oq}, 32'h0000_0000);
    i_nrst = 1'b1;
    for (int k = 0; k < 23; k++) begin
      if (k < 16) begin
        nxt_i = sample_t'(16'h8000 + 16'(k) * 16'h1111);
        nxt_q = ~nxt_i;
        v[k] = {nxt_i, nxt_q};
      end
      if (k >= 6 && k < 22) chk("bypass out", {oi, oq}, v[k - 6]);
      tick(1);
    end
    qmc(11'h200, 12'h000, 13'h0000, 13'h0000, 16'sh1000, 16'sh0800, {16'h0800, 16'h0400});
    qmc(11'h7FF, 12'h000, 13'h0000, 13'h0000, 16'sh7000, 16'sh8000, {16'h7FFF, 16'h8000});
    qmc(GAIN_ONE, 12'h800, 13'h0000, 13'h0000, 16'sh0100, 16'sh1000, {16'hF900, 16'h1000});
    qmc(GAIN_ONE, 12'h000, 13'h0FFF, 13'h1000, 16'sh0010, 16'sh0000, {16'h100F, 16'hF000});
    qmc(GAIN_ONE, 12'h000, 13'h0FFF, 13'h1000, 16'sh7FF0, 16'sh8010, {16'h7FFF, 16'h8000});
    qmc(GAIN_ONE, 12'h000, 13'h0000, 13'h0000, 16'sh1000, 16'sh0800, {16'h1000, 16'h0800});
    mgain = 1'b0;
    for (int j = 0; j < 4; j++) begin
      csel = cs[j];
      tick(10);
      p = -1;
      for (int r = 3; r >= 0; r--) if ({oi, oq} === rj(r * st[j], 16'sh1000, 16'sh0800)) p = r;
      chk("coarse align", p >= 0, 32'h1);
      for (int n = 1; n < 5; n++) begin
        tick(1);
        chk("coarse seq", {oi, oq}, rj((p + n) * st[j], 16'sh1000, 16'sh0800));
      end
    end
    for (int j = 0; j < 5; j++) begin
      csel = fc[j];
      mgain = (j != 1);
      tick(10);
      hits = 0;
      for (int n = 0; n < 16; n++) begin
        v[n] = {oi, oq};
        tick(1);
      end
      for (int n = 0; n < 8; n++) begin
        chk("fs8 period", v[n + 8], v[n]);
        for (int r = 0; r < 4; r++) begin
          if (v[n] === rj(r, mgain ? 16'sh0FFF : 16'sh07FF, mgain ? 16'sh07FF : 16'sh03FF)) hits++;
        end
      end
      chk("fs8 unit hits", hits, 32'h1);
    end
    csel = 4'h0;
    full = 1'b1;
    mix(16'h0000, 1'b1, {16'h0FFF, 16'h07FF});
    mix(16'h0000, 1'b0, {16'h07FF, 16'h03FF});
    qgain = 11'h5A8;
    mix(16'h0000, 1'b0, {16'h0B4E, 16'h05A6});
    qgain = GAIN_ONE;
    mix(16'h4000, 1'b1, {16'hF800, 16'h0FFF});
    mix(16'h8000, 1'b1, {16'hF000, 16'hF800});
    full = 1'b0;
    poff = 16'h0000;
    freq = 32'h0123_4567;
    tick(2);
    p0 = ph;
    tick(1);
    chk("phase step", ph - p0, freq);
    for (int n = 0; n < 4; n++) begin
      ssel = 4'(1 << n);
      spins = 4'(1 << n);
      hits = 0;
      for (int k = 0; k < 12; k++) begin
        tick(1);
        if (ph === ACC_RST) hits++;
      end
      chk("sync clear", hits, 32'h1);
      spins = 4'h0;
      tick(4);
    end
    ssel = 4'h1;
    p0 = ph;
    spins = 4'h2;
    tick(12);
    chk("sync masked", ph - p0, 32'h0000_000C * freq);
    spins = 4'h0;
    results();
  end
endmodule
`default_nettype wire
